/* File: src/gtsv_params.svh */
// Purpose: Named offsets, field positions and codes for the table switch and fault logic
// Assumes: Included by the design file only
// Notes: Offsets are byte addresses on the 8-bit register port
`ifndef GTSV_PARAMS_SVH
`define GTSV_PARAMS_SVH

// Information area, as laid out in memory
`define GTSV_OFF_EXIT_REASON 8'h00
`define GTSV_OFF_BUSY_WORD 8'h04
`define GTSV_OFF_QUAL_LO 8'h08
`define GTSV_OFF_QUAL_HI 8'h0c
`define GTSV_OFF_GLA_LO 8'h10
`define GTSV_OFF_GLA_HI 8'h14
`define GTSV_OFF_GPA_LO 8'h18
`define GTSV_OFF_GPA_HI 8'h1c
`define GTSV_OFF_PTR_INDEX 8'h20
// Control and status
`define GTSV_OFF_CONFIG 8'h40
`define GTSV_OFF_STATUS 8'h44
`define GTSV_OFF_FN_CTL_LO 8'h48
`define GTSV_OFF_FN_CTL_HI 8'h4c
`define GTSV_OFF_LIST_LO 8'h50
`define GTSV_OFF_LIST_HI 8'h54
`define GTSV_OFF_ROOT_LO 8'h58
`define GTSV_OFF_ROOT_HI 8'h5c
`define GTSV_OFF_IDX_CTL 8'h60

// Configuration bits
`define GTSV_CFG_FN_ENABLE 0
`define GTSV_CFG_VE_ENABLE 1
`define GTSV_CFG_VIRTUAL_PROCESSOR_TAG_ENABLE 2
`define GTSV_CFG_EXC_BITMAP20 3
`define GTSV_CFG_WIDTH 4
`define GTSV_CFG_RESET 4'h0

// Function call
`define GTSV_FN_MAX 32'h0000_003f
`define GTSV_FN_SWITCH 6'h00
`define GTSV_LIST_LIMIT 32'h0000_0200
`define GTSV_VE_SUPPORTED 1'b1

// Exit reasons and vectors
`define GTSV_REASON_FN_CALL 16'h003b
`define GTSV_REASON_VIOLATION 32'h0000_0030
`define GTSV_REASON_MISCONFIG 16'h0031
`define GTSV_REASON_EXCEPTION 16'h0000
`define GTSV_VE_VECTOR 8'h14
`define GTSV_BUSY_SET 32'hffff_ffff

// Root pointer and paging entry fields
`define GTSV_MT_UC 3'h0
`define GTSV_MT_WB 3'h6
`define GTSV_WALK_LEN 3'h3
`define GTSV_LEAF_BIT 7
`define GTSV_SUPPRESS_BIT 63

`endif

/* File: src/gtsv_pkg.sv */
// Purpose: Types shared by the table switch and fault logic
// Assumes: Nothing
// Notes: One-hot state codes
package gtsv_pkg;
	typedef enum logic [2:0] {
		gtsv_idle = 3'b001,
		gtsv_fetch = 3'b010,
		gtsv_check = 3'b100
	} gtsv_state_t;
endpackage

/* File: src/gtsv_switch_ve.sv */
// Purpose: Guest root pointer switch by list index, and violation to in-guest fault conversion
// Assumes: One clock; list entries are fetched over a simple valid-handshake memory port
// Notes: The information area is held here as registers readable over the register port
//
// Design decision made here: the address-and-strobe port.
`include "gtsv_params.svh"

// Notes on behaviour
// - Index 512 or above exits and keeps the current root pointer.
// - In-range index fetches eight bytes at list base plus eight times index.
// - A candidate failing entry checks exits and is not installed.
// - A valid candidate becomes the root pointer used for later translations.
// - With fault conversion supported, a switch stores index bits 15:0 as pointer index.
// - A successful switch modifies no register or flag; execution continues.
// - A switch exit reports reason 59 and instruction length only.
// - New mappings are tagged by pointer bits 51:12 with unchanged processor tags.
// - With processor tags disabled, a switch flushes mappings of tag 0000H.
// - The switch never raises violation or misconfiguration itself.
// - Under extended paging, cached directory entries are not reloaded by a switch.
// - The fault uses vector 20 and arises only in guest operation.
// - With conversion disabled, every violation exits.
// - Not-present entry violation converts only when its bit 63 is zero.
// - Unsupported entries raise misconfiguration, which always exits.
// - Page-mapping entry bit 63 decides; non-leaf bit 63 is ignored.
// - Conversion needs protection on, no table delivery, and busy word zero.
// - Delivery writes all ones to the busy word; software must clear it.
// - Area holds reason 48, qualification, linear and physical addresses.
// - Current 16-bit pointer index is stored at area offset 32.
// - Disabled calls or function above 63 are invalid; disabled function exits.
// - Exception bitmap bit 20 set exits; otherwise gate 20 without error code.
module gtsv_switch_ve (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic guest_mode,
	input wire logic fn_req,
	input wire logic [31:0] function_select_register,
	input wire logic [31:0] list_index_register,
	input wire logic [3:0] instr_len,
	output logic mem_req,
	output logic [63:0] mem_addr,
	input wire logic mem_valid,
	input wire logic [63:0] mem_data,
	input wire logic viol_valid,
	input wire logic [63:0] viol_entry,
	input wire logic viol_entry_pte,
	input wire logic [63:0] viol_qual,
	input wire logic [63:0] viol_gla,
	input wire logic [63:0] viol_gpa,
	input wire logic misconfig_valid,
	input wire logic protection_enable_bit,
	input wire logic idt_delivery,
	output logic fn_done,
	output logic ud_raise,
	output logic vm_exit,
	output logic [15:0] exit_reason,
	output logic [3:0] exit_instr_len,
	output logic ve_deliver,
	output logic [7:0] ve_vector,
	output logic vpid0_flush,
	output logic [63:0] root_table_pointer
);

	gtsv_pkg::gtsv_state_t state;
	logic [`GTSV_CFG_WIDTH-1:0] cfg;
	logic [63:0] fn_ctl;
	logic [63:0] list_base;
	logic [15:0] idx_ctl;
	logic [31:0] ve_exit_reason;
	logic [31:0] ve_busy_word;
	logic [63:0] ve_exit_qualification;
	logic [63:0] ve_guest_linear_address;
	logic [63:0] ve_guest_physical_address;
	logic [15:0] ve_pointer_index;
	logic [63:0] cand;
	logic [15:0] held_index;
	logic [3:0] held_len;
	logic fn_take;
	logic fn_ud;
	logic fn_off;
	logic idx_bad;
	logic cand_ok;
	logic convertible;
	logic ve_take;
	logic viol_exit;
	logic misc_exit;
	logic sw_ok;

	// Requests are taken only when idle and no violation competes in the cycle
	assign fn_take = fn_req && guest_mode && (state == gtsv_pkg::gtsv_idle)
		&& !viol_valid && !misconfig_valid;
	assign fn_ud = !cfg[`GTSV_CFG_FN_ENABLE] || (function_select_register > `GTSV_FN_MAX);
	assign fn_off = !fn_ctl[function_select_register[5:0]]
		|| (function_select_register[5:0] != `GTSV_FN_SWITCH);
	assign idx_bad = list_index_register >= `GTSV_LIST_LIMIT;

	// Candidate validity, reserved bits and supported encodings
	assign cand_ok = ((cand[2:0] == `GTSV_MT_UC) || (cand[2:0] == `GTSV_MT_WB))
		&& (cand[5:3] == `GTSV_WALK_LEN) && (cand[11:7] == 5'h00)
		&& (cand[63:52] == 12'h000);
	assign sw_ok = (state == gtsv_pkg::gtsv_check) && cand_ok;

	// Deciding entry: not-present or page-mapping entries use bit 63
	assign convertible = !viol_entry[`GTSV_SUPPRESS_BIT]
		&& ((viol_entry[2:0] == 3'h0) || viol_entry[`GTSV_LEAF_BIT] || viol_entry_pte);
	assign ve_take = viol_valid && !misconfig_valid && guest_mode
		&& cfg[`GTSV_CFG_VE_ENABLE] && convertible && protection_enable_bit
		&& !idt_delivery && (ve_busy_word == 32'h0000_0000);
	assign viol_exit = viol_valid && !misconfig_valid && guest_mode && !ve_take;
	assign misc_exit = misconfig_valid && guest_mode;

	// Call sequencing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= gtsv_pkg::gtsv_idle;
			mem_req <= 1'b0;
			mem_addr <= 64'h0000_0000_0000_0000;
			cand <= 64'h0000_0000_0000_0000;
			held_index <= 16'h0000;
			held_len <= 4'h0;
		end else begin
			case (state)
				gtsv_pkg::gtsv_idle: begin
					if (fn_take && !fn_ud && !fn_off && !idx_bad) begin
						mem_req <= 1'b1;
						mem_addr <= list_base + 64'({list_index_register[8:0], 3'b000});
						held_index <= list_index_register[15:0];
						held_len <= instr_len;
						state <= gtsv_pkg::gtsv_fetch;
					end
				end
				gtsv_pkg::gtsv_fetch: begin
					if (mem_valid) begin
						mem_req <= 1'b0;
						cand <= mem_data;
						state <= gtsv_pkg::gtsv_check;
					end
				end
				gtsv_pkg::gtsv_check: begin
					state <= gtsv_pkg::gtsv_idle;
				end
				default: begin
					state <= gtsv_pkg::gtsv_idle;
					mem_req <= 1'b0;
				end
			endcase
		end
	end

	// Outcome pulses and exit information
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fn_done <= 1'b0;
			ud_raise <= 1'b0;
			vm_exit <= 1'b0;
			exit_reason <= 16'h0000;
			exit_instr_len <= 4'h0;
			ve_deliver <= 1'b0;
			ve_vector <= `GTSV_VE_VECTOR;
			vpid0_flush <= 1'b0;
		end else begin
			fn_done <= 1'b0;
			ud_raise <= 1'b0;
			vm_exit <= 1'b0;
			ve_deliver <= 1'b0;
			vpid0_flush <= 1'b0;
			if (misc_exit) begin
				vm_exit <= 1'b1;
				exit_reason <= `GTSV_REASON_MISCONFIG;
				exit_instr_len <= 4'h0;
			end else if (viol_exit) begin
				vm_exit <= 1'b1;
				exit_reason <= 16'(`GTSV_REASON_VIOLATION);
				exit_instr_len <= 4'h0;
			end else if (ve_take) begin
				if (cfg[`GTSV_CFG_EXC_BITMAP20]) begin
					vm_exit <= 1'b1;
					exit_reason <= `GTSV_REASON_EXCEPTION;
					exit_instr_len <= 4'h0;
				end else begin
					ve_deliver <= 1'b1;
					ve_vector <= `GTSV_VE_VECTOR;
				end
			end else if (fn_take && fn_ud) begin
				ud_raise <= 1'b1;
			end else if (fn_take && (fn_off || idx_bad)) begin
				vm_exit <= 1'b1;
				exit_reason <= `GTSV_REASON_FN_CALL;
				exit_instr_len <= instr_len;
			end else if (state == gtsv_pkg::gtsv_check) begin
				if (cand_ok) begin
					fn_done <= 1'b1;
					vpid0_flush <= !cfg[`GTSV_CFG_VIRTUAL_PROCESSOR_TAG_ENABLE];
				end else begin
					vm_exit <= 1'b1;
					exit_reason <= `GTSV_REASON_FN_CALL;
					exit_instr_len <= held_len;
				end
			end
		end
	end

	// Root pointer and pointer index; the hardware install wins over a software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			root_table_pointer <= 64'h0000_0000_0000_0000;
			idx_ctl <= 16'h0000;
		end else begin
			// Install only; no walk or directory reload here
			if (sw_ok) begin
				root_table_pointer <= cand;
			end else if (reg_wr && (reg_addr == `GTSV_OFF_ROOT_LO)) begin
				root_table_pointer[31:0] <= reg_wdata;
			end else if (reg_wr && (reg_addr == `GTSV_OFF_ROOT_HI)) begin
				root_table_pointer[63:32] <= reg_wdata;
			end
			if (sw_ok && `GTSV_VE_SUPPORTED) begin
				idx_ctl <= held_index;
			end else if (reg_wr && (reg_addr == `GTSV_OFF_IDX_CTL)) begin
				idx_ctl <= reg_wdata[15:0];
			end
		end
	end

	// Hypervisor configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `GTSV_CFG_RESET;
			fn_ctl <= 64'h0000_0000_0000_0000;
			list_base <= 64'h0000_0000_0000_0000;
		end else if (reg_wr) begin
			case (reg_addr)
				`GTSV_OFF_CONFIG: cfg <= reg_wdata[`GTSV_CFG_WIDTH-1:0];
				`GTSV_OFF_FN_CTL_LO: fn_ctl[31:0] <= reg_wdata;
				`GTSV_OFF_FN_CTL_HI: fn_ctl[63:32] <= reg_wdata;
				`GTSV_OFF_LIST_LO: list_base[31:0] <= {reg_wdata[31:12], 12'h000};
				`GTSV_OFF_LIST_HI: list_base[63:32] <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Information area; the delivery write wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ve_exit_reason <= 32'h0000_0000;
			ve_busy_word <= 32'h0000_0000;
			ve_exit_qualification <= 64'h0000_0000_0000_0000;
			ve_guest_linear_address <= 64'h0000_0000_0000_0000;
			ve_guest_physical_address <= 64'h0000_0000_0000_0000;
			ve_pointer_index <= 16'h0000;
		end else begin
			if (ve_take) begin
				ve_busy_word <= `GTSV_BUSY_SET;
				ve_exit_reason <= `GTSV_REASON_VIOLATION;
				ve_exit_qualification <= viol_qual;
				ve_guest_linear_address <= viol_gla;
				ve_guest_physical_address <= viol_gpa;
				ve_pointer_index <= idx_ctl;
			end else if (reg_wr && (reg_addr == `GTSV_OFF_BUSY_WORD)) begin
				ve_busy_word <= reg_wdata;
			end
		end
	end

	// Register read port, data in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`GTSV_OFF_EXIT_REASON: reg_rdata <= ve_exit_reason;
				`GTSV_OFF_BUSY_WORD: reg_rdata <= ve_busy_word;
				`GTSV_OFF_QUAL_LO: reg_rdata <= ve_exit_qualification[31:0];
				`GTSV_OFF_QUAL_HI: reg_rdata <= ve_exit_qualification[63:32];
				`GTSV_OFF_GLA_LO: reg_rdata <= ve_guest_linear_address[31:0];
				`GTSV_OFF_GLA_HI: reg_rdata <= ve_guest_linear_address[63:32];
				`GTSV_OFF_GPA_LO: reg_rdata <= ve_guest_physical_address[31:0];
				`GTSV_OFF_GPA_HI: reg_rdata <= ve_guest_physical_address[63:32];
				`GTSV_OFF_PTR_INDEX: reg_rdata <= {16'h0000, ve_pointer_index};
				`GTSV_OFF_CONFIG: reg_rdata <= {28'h000_0000, cfg};
				`GTSV_OFF_STATUS: reg_rdata <= {29'h0000_0000, state};
				`GTSV_OFF_FN_CTL_LO: reg_rdata <= fn_ctl[31:0];
				`GTSV_OFF_FN_CTL_HI: reg_rdata <= fn_ctl[63:32];
				`GTSV_OFF_LIST_LO: reg_rdata <= list_base[31:0];
				`GTSV_OFF_LIST_HI: reg_rdata <= list_base[63:32];
				`GTSV_OFF_ROOT_LO: reg_rdata <= root_table_pointer[31:0];
				`GTSV_OFF_ROOT_HI: reg_rdata <= root_table_pointer[63:32];
				`GTSV_OFF_IDX_CTL: reg_rdata <= {16'h0000, idx_ctl};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	a_index_range_exit: assert property (@(posedge clk) disable iff (!rst_n)
		fn_take && !fn_ud && !fn_off && idx_bad
		|=> vm_exit && (exit_reason == `GTSV_REASON_FN_CALL) && $stable(root_table_pointer)
		&& (state == gtsv_pkg::gtsv_idle))
		else $error("out of range index did not exit cleanly");

	a_fetch_address: assert property (@(posedge clk) disable iff (!rst_n)
		fn_take && !fn_ud && !fn_off && !idx_bad
		|=> mem_req && (mem_addr == $past(list_base) + 64'({$past(list_index_register[8:0]), 3'b000}))
		&& (held_index == $past(list_index_register[15:0])))
		else $error("list fetch address wrong");

	a_bad_candidate: assert property (@(posedge clk) disable iff (!rst_n)
		(state == gtsv_pkg::gtsv_check) && !cand_ok
		|=> vm_exit && !fn_done && (root_table_pointer != $past(cand) || $past(cand) == $past(root_table_pointer)))
		else $error("bad candidate installed or no exit");

	a_root_install: assert property (@(posedge clk) disable iff (!rst_n)
		sw_ok |=> (root_table_pointer == $past(cand)) && fn_done && !vm_exit)
		else $error("valid candidate not installed");

	a_index_copy: assert property (@(posedge clk) disable iff (!rst_n)
		sw_ok |=> (idx_ctl == $past(held_index)) && (state == gtsv_pkg::gtsv_idle))
		else $error("pointer index not copied");

	a_tag_flush: assert property (@(posedge clk) disable iff (!rst_n)
		sw_ok && !cfg[`GTSV_CFG_VIRTUAL_PROCESSOR_TAG_ENABLE] |=> vpid0_flush ##1 !vpid0_flush)
		else $error("tag zero flush missing");

	a_conv_off_exit: assert property (@(posedge clk) disable iff (!rst_n)
		viol_valid && guest_mode && !misconfig_valid && !cfg[`GTSV_CFG_VE_ENABLE]
		|=> vm_exit && (exit_reason == 16'(`GTSV_REASON_VIOLATION)) && !ve_deliver)
		else $error("violation not exited with conversion off");

	a_misconfig_exit: assert property (@(posedge clk) disable iff (!rst_n)
		misc_exit |=> vm_exit && !ve_deliver && (exit_reason == `GTSV_REASON_MISCONFIG))
		else $error("misconfiguration not exited");

	// Busy word blocks a second fault
	a_busy_block: assert property (@(posedge clk) disable iff (!rst_n)
		ve_take ##1 !(reg_wr && reg_addr == `GTSV_OFF_BUSY_WORD)
		|=> (ve_busy_word == `GTSV_BUSY_SET) && !ve_take)
		else $error("busy word not held after delivery");

	a_gate_vector: assert property (@(posedge clk) disable iff (!rst_n)
		ve_take && !cfg[`GTSV_CFG_EXC_BITMAP20]
		|=> ve_deliver && (ve_vector == `GTSV_VE_VECTOR) && !vm_exit)
		else $error("fault not delivered through gate 20");

endmodule

/* File: dv/gtsv_switch_ve_tb.sv */
// Purpose: Self-checking bench for the root pointer switch and fault conversion
// Assumes: Registered outputs are looked at 1 ns after the rising edge
// Notes: Inputs change by non-blocking assignment on the rising edge
module gtsv_switch_ve_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic guest_mode = 1'b1;
	logic fn_req = 1'b0;
	logic [31:0] fsel = 32'h0000_0000;
	logic [31:0] lidx = 32'h0000_0000;
	logic [3:0] instr_len = 4'h3;
	logic mem_req, mem_valid = 1'b0;
	logic [63:0] mem_addr, mem_data = 64'h0;
	logic viol_valid = 1'b0, viol_entry_pte = 1'b0, misconfig_valid = 1'b0;
	logic [63:0] viol_entry = 64'h0, vq = 64'h0, vla = 64'h0, vpa = 64'h0;
	logic pe = 1'b1, interrupt_descriptor_table = 1'b0;
	logic fn_done, ud_raise, vm_exit, ve_deliver, vpid0_flush;
	logic [15:0] exit_reason;
	logic [3:0] exit_instr_len;
	logic [7:0] ve_vector;
	logic [63:0] root;
	int fail_count = 0, num_checks = 0, cyc = 0;
	logic [31:0] rv;
	logic [3:0] res;
	logic [1:0] vr;
	// Fetch base 0x1_0001_2345 with its low 12 bits forced to zero
	localparam logic [63:0] BASE = 64'h0000_0001_0001_2000;
	localparam logic [63:0] C1 = 64'h0000_0000_bcde_f01e;
	localparam logic [63:0] C2 = 64'h000f_ffff_ffff_f05e;

	gtsv_switch_ve i_gtsv_switch_ve (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .guest_mode, .fn_req, .function_select_register(fsel),
		.list_index_register(lidx), .instr_len, .mem_req, .mem_addr, .mem_valid, .mem_data,
		.viol_valid, .viol_entry, .viol_entry_pte, .viol_qual(vq), .viol_gla(vla),
		.viol_gpa(vpa), .misconfig_valid, .protection_enable_bit(pe), .idt_delivery(interrupt_descriptor_table),
		.fn_done, .ud_raise, .vm_exit, .exit_reason, .exit_instr_len, .ve_deliver, .ve_vector,
		.vpid0_flush, .root_table_pointer(root));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// A hang is cut short well past the roughly 150 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	// Result packs ud_raise, vm_exit, fn_done and vpid0_flush
	task automatic call(input logic [31:0] fn, input logic [31:0] idx,
		input logic [63:0] cand, input logic [63:0] eaddr);
		int n;
		@(posedge clk);
		fn_req <= 1'b1;
		fsel <= fn;
		lidx <= idx;
		@(posedge clk);
		fn_req <= 1'b0;
		fsel <= ~fn;
		lidx <= ~idx;
		#1;
		if (mem_req === 1'b1) begin
			chk(mem_addr, eaddr, "fetch address");
			@(posedge clk);
			mem_valid <= 1'b1;
			mem_data <= cand;
			@(posedge clk);
			mem_valid <= 1'b0;
			mem_data <= ~cand;
			#1;
		end
		n = 0;
		while (n < 6 && fn_done !== 1'b1 && vm_exit !== 1'b1 && ud_raise !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		res = {ud_raise, vm_exit, fn_done, vpid0_flush};
	endtask

	task automatic viol(input logic [63:0] ent, input logic pte, input logic mis);
		@(posedge clk);
		viol_valid <= ~mis;
		misconfig_valid <= mis;
		viol_entry <= ent;
		viol_entry_pte <= pte;
		vq <= 64'h1111_2222_3333_4444;
		vla <= 64'h5555_6666_7777_8888;
		vpa <= 64'h0000_0009_aaaa_b000;
		@(posedge clk);
		viol_valid <= 1'b0;
		misconfig_valid <= 1'b0;
		viol_entry <= ~ent;
		vq <= ~vq;
		#1;
		vr = {vm_exit, ve_deliver};
	endtask

	task automatic t_reset();
		rd(8'h58);
		chk(rv, 64'h0, "root after reset");
		rd(8'h04);
		chk(rv, 64'h0, "busy after reset");
		rd(8'h80);
		chk(rv, 64'h0, "unmapped read");
		chk(ve_vector, 8'h14, "vector");
		$display("reset test done");
	endtask

	task automatic t_switch();
		call(32'h0000_0000, 32'h0000_0200, C1, 64'h0);
		chk(res, 4'h4, "index 512 exits");
		chk(exit_reason, 16'h003b, "exit reason");
		chk(exit_instr_len, 4'h3, "exit length");
		chk(root, 64'h0, "root kept");
		call(32'h0000_0000, 32'h0000_0005, C1, BASE + 64'h28);
		chk(res, 4'h3, "switch and flush");
		chk(root, C1, "root port");
		rd(8'h58);
		chk(rv, C1[31:0], "root low word");
		rd(8'h60);
		chk(rv, 32'h0000_0005, "index control");
		// Fresh root bits, tag 0000H flush still owed with processor tags off
		call(32'h0000_0000, 32'h0000_01ff, C2, BASE + 64'hff8);
		chk(res, 4'h3, "last entry");
		rd(8'h5c);
		chk(rv, C2[63:32], "root high word");
		$display("switch test done");
	endtask

	task automatic t_bad();
		call(32'h0000_0000, 32'h0000_0007, 64'h0000_0000_bcde_f016, BASE + 64'h38);
		chk(res, 4'h4, "bad walk length");
		chk(exit_reason, 16'h003b, "check exit reason");
		chk(exit_instr_len, 4'h3, "check exit length");
		call(32'h0000_0000, 32'h0000_0008, 64'h0010_0000_0000_001e, BASE + 64'h40);
		chk(res, 4'h4, "bad high bits");
		chk(root, C2, "root not installed");
		rd(8'h60);
		chk(rv, 32'h0000_01ff, "index kept");
		call(32'h0000_0000, 32'h0000_0009, 64'h0000_0000_0001_2018, BASE + 64'h48);
		chk(res, 4'h3, "uncached type");
		$display("candidate test done");
	endtask

	task automatic t_fn();
		call(32'h0000_0040, 32'h0000_0000, C1, 64'h0);
		chk(res, 4'h8, "function 64");
		call(32'h0000_0001, 32'h0000_0000, C1, 64'h0);
		chk(res, 4'h4, "disabled function");
		chk(exit_reason, 16'h003b, "disabled reason");
		wr(8'h40, 32'h0000_0007);
		call(32'h0000_0000, 32'h0000_0003, C1, BASE + 64'h18);
		chk(res, 4'h2, "no flush with tags");
		wr(8'h40, 32'h0000_0006);
		call(32'h0000_0000, 32'h0000_0003, C1, BASE + 64'h18);
		chk(res, 4'h8, "calls disabled");
		wr(8'h40, 32'h0000_0003);
		@(posedge clk);
		guest_mode <= 1'b0;
		call(32'h0000_0000, 32'h0000_0004, C2, BASE + 64'h20);
		chk(res, 4'h0, "root mode call");
		chk(root, C1, "root mode kept");
		@(posedge clk);
		guest_mode <= 1'b1;
		$display("function test done");
	endtask

	task automatic t_ve();
		logic [31:0] ev [9];
		logic [63:0] ent [6];
		logic [5:0] pt, pv, iv, mv;
		ev = '{32'h0000_0030, 32'hffff_ffff, 32'h3333_4444, 32'h1111_2222, 32'h7777_8888,
			32'h5555_6666, 32'haaaa_b000, 32'h0000_0009, 32'h0000_00a5};
		ent = '{64'h8000_0000_0000_0000, 64'h8000_0000_0000_0087, 64'h8000_0000_0000_0007,
			64'h0, 64'h0, 64'h0};
		pt = 6'h04;
		pv = 6'h37;
		iv = 6'h10;
		mv = 6'h20;
		wr(8'h60, 32'h0000_00a5);
		viol(64'h0, 1'b0, 1'b0);
		chk(vr, 2'h1, "fault delivered");
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4));
			chk(rv, ev[i], "info area");
		end
		wr(8'h00, 32'h1234_5678);
		rd(8'h00);
		chk(rv, 32'h0000_0030, "read-only reason");
		viol(64'h0, 1'b0, 1'b0);
		chk(vr, 2'h2, "busy word set");
		wr(8'h04, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			pe <= pv[i];
			interrupt_descriptor_table <= iv[i];
			viol(ent[i], pt[i], mv[i]);
			chk(vr, 2'h2, "not convertible");
			chk(exit_reason, mv[i] ? 16'h0031 : 16'h0030, "violation reason");
		end
		@(posedge clk);
		pe <= 1'b1;
		interrupt_descriptor_table <= 1'b0;
		viol(64'h0000_0000_0000_0087, 1'b0, 1'b0);
		chk(vr, 2'h1, "large page converts");
		wr(8'h04, 32'h0000_0000);
		wr(8'h40, 32'h0000_0001);
		viol(64'h0, 1'b0, 1'b0);
		chk(vr, 2'h2, "conversion off");
		wr(8'h40, 32'h0000_000b);
		viol(64'h0, 1'b0, 1'b0);
		chk(vr[1], 1'b1, "bitmap exits");
		chk(exit_reason, 16'h0000, "bitmap reason");
		wr(8'h04, 32'h0000_0000);
		@(posedge clk);
		guest_mode <= 1'b0;
		viol(64'h0, 1'b0, 1'b0);
		chk(vr, 2'h0, "root mode ignored");
		$display("fault test done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		wr(8'h40, 32'h0000_0003);
		wr(8'h48, 32'h0000_0001);
		wr(8'h4c, 32'h0000_0000);
		wr(8'h50, 32'h0001_2345);
		wr(8'h54, 32'h0000_0001);
		t_switch();
		t_bad();
		t_fn();
		t_ve();
		results();
	end
endmodule
